// *** logic/dhsi_pkg.sv ***
// Package: register map, field layout and carrier types of the DMA/HDLC status block
package dhsi_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] MST_STATUS_OFS = 8'h20;
    localparam logic [7:0] MST_MASK_OFS = 8'h24;
    localparam logic [7:0] DMA_STATUS_OFS = 8'h28;
    localparam logic [7:0] DMA_MASK_OFS = 8'h2C;
    localparam logic [7:0] RX_QCTL_OFS = 8'h30;
    localparam logic [7:0] TX_QCTL_OFS = 8'h34;
    localparam logic [7:0] DMA_CLEAR_OFS = 8'h38;

    localparam int unsigned MST_PAR_BIT = 4;
    localparam int unsigned MST_LBE_BIT = 14;
    localparam int unsigned MST_LBI_BIT = 15;
    localparam logic [15:0] MST_IMPL = 16'hC010;

    localparam int unsigned CRC_BIT = 2;
    localparam int unsigned ABRT_BIT = 3;
    localparam int unsigned LEN_BIT = 4;
    localparam int unsigned OVFL_BIT = 5;
    localparam int unsigned LFR_BIT = 6;
    localparam int unsigned LFE_BIT = 7;
    localparam int unsigned SFR_BIT = 8;
    localparam int unsigned SFE_BIT = 9;
    localparam int unsigned RDW_BIT = 10;
    localparam int unsigned RDF_BIT = 11;
    localparam int unsigned UDFL_BIT = 12;
    localparam int unsigned TPR_BIT = 13;
    localparam int unsigned TDW_BIT = 14;
    localparam int unsigned TDF_BIT = 15;
    localparam logic [15:0] DMA_IMPL = 16'hFFFC;

    localparam int unsigned THR_LSB = 0;
    localparam int unsigned THR_W = 3;
    localparam int unsigned QCNT_W = 8;
    localparam logic [15:0] REG_RESET = 16'h0000;
    localparam logic [2:0] THR_RESET = 3'h0;

    typedef struct packed {
        logic crc_err;
        logic abort;
        logic len_err;
        logic rx_ovfl;
        logic large_read;
        logic large_empty;
        logic small_read;
        logic small_empty;
        logic rx_done_wr;
        logic rx_done_full;
        logic tx_udfl;
        logic pend_read;
        logic tx_done_wr;
        logic tx_done_full;
    } dhsi_dma_evt_t;

    typedef struct packed {
        logic parity_err;
        logic lbus_timeout;
        logic lbus_irq;
    } dhsi_mst_evt_t;
endpackage : dhsi_pkg

// *** logic/dhsi_status_irq.sv ***
// DMA/HDLC event status, interrupt masks and interrupt pins behind an APB slave
//
// Functional notes
// - Master mask bits 4,14,15 gate master events
// - DMA status at 0x28, resets zero, 1:0 reserved
// - Bit 2 latches CRC error, read clears
// - Bit 3 latches abort, read clears
// - Bit 4 latches length violations, read clears
// - Bit 5 latches receive FIFO overflow
// - Bit 6 latches large free-queue read
// - Bit 7 latches large free-queue empty read
// - Bit 8 latches small free-queue read
// - Bit 9 latches small free-queue empty read
// - Bit 10 per receive done-queue threshold
// - Bit 11 latches receive done-queue full write
// - Bit 12 latches transmit FIFO underflow
// - Bit 13 latches pending-queue read
// - Bit 14 per transmit done-queue threshold
// - Bit 15 latches transmit done-queue full write
// - Unmasked DMA bits drive host pin, and local pin only in configuration mode
// - DMA mask at 0x2C, resets zero
//
// Chosen here: the APB register port.
`timescale 1ns/1ps
module dhsi_status_irq (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dhsi_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire dhsi_pkg::dhsi_dma_evt_t dma_evt,
    input wire dhsi_pkg::dhsi_mst_evt_t mst_evt,
    input wire logic local_cfg_mode,
    output logic host_irq_pin,
    output logic local_irq_pin
);
    import dhsi_pkg::*;

    // Done-queue threshold: 0 means every write, k means 2**k writes
    function automatic logic thr_hit(input logic [QCNT_W-1:0] cnt, input logic [THR_W-1:0] thr);
        logic [QCNT_W:0] need;
        need = 9'h001 << thr;
        thr_hit = ({1'b0, cnt} + 9'h001) >= need;
    endfunction : thr_hit

    function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
                                              input logic [3:0] be);
        lane_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction : lane_merge

    logic [15:0] dma_status_q;
    logic [15:0] dma_status_d;
    logic [15:0] dma_mask_q;
    logic [15:0] mst_status_q;
    logic [15:0] mst_status_d;
    logic [15:0] mst_mask_q;
    logic [THR_W-1:0] rx_thr_q;
    logic [THR_W-1:0] tx_thr_q;
    logic [QCNT_W-1:0] rx_cnt_q;
    logic [QCNT_W-1:0] rx_cnt_d;
    logic [QCNT_W-1:0] tx_cnt_q;
    logic [QCNT_W-1:0] tx_cnt_d;
    logic [31:0] prdata_q;
    logic [31:0] prdata_d;
    logic pready_q;
    logic pslverr_q;
    logic pslverr_d;
    logic host_irq_q;
    logic local_irq_q;
    logic cfg_meta_q;
    logic cfg_sync_q;

    // APB decode: one wait state, request completes when pready_q is high
    wire access = psel & penable;
    wire done = access & pready_q;
    wire wr_done = done & pwrite;
    wire rd_done = done & ~pwrite;
    wire sel_mst_st = paddr == MST_STATUS_OFS;
    wire sel_mst_mk = paddr == MST_MASK_OFS;
    wire sel_dma_st = paddr == DMA_STATUS_OFS;
    wire sel_dma_mk = paddr == DMA_MASK_OFS;
    wire sel_rxq = paddr == RX_QCTL_OFS;
    wire sel_txq = paddr == TX_QCTL_OFS;
    wire sel_clr = paddr == DMA_CLEAR_OFS;
    wire mapped = sel_mst_st | sel_mst_mk | sel_dma_st | sel_dma_mk | sel_rxq | sel_txq | sel_clr;
    wire [15:0] wmask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

    wire [15:0] dma_rd_clr = (rd_done & sel_dma_st) ? DMA_IMPL : 16'h0000;
    wire [15:0] dma_wr_clr = (wr_done & sel_clr) ? (pwdata[15:0] & wmask & DMA_IMPL) : 16'h0000;
    wire [15:0] mst_rd_clr = (rd_done & sel_mst_st) ? MST_IMPL : 16'h0000;

    wire rx_hit = dma_evt.rx_done_wr & thr_hit(rx_cnt_q, rx_thr_q);
    wire tx_hit = dma_evt.tx_done_wr & thr_hit(tx_cnt_q, tx_thr_q);
    assign rx_cnt_d = rx_hit ? 8'h00 : (dma_evt.rx_done_wr ? rx_cnt_q + 8'h01 : rx_cnt_q);
    assign tx_cnt_d = tx_hit ? 8'h00 : (dma_evt.tx_done_wr ? tx_cnt_q + 8'h01 : tx_cnt_q);

    wire [15:0] dma_set = {
        dma_evt.tx_done_full,
        tx_hit,
        dma_evt.pend_read,
        dma_evt.tx_udfl,
        dma_evt.rx_done_full,
        rx_hit,
        dma_evt.small_empty,
        dma_evt.small_read,
        dma_evt.large_empty,
        dma_evt.large_read,
        dma_evt.rx_ovfl,
        dma_evt.len_err,
        dma_evt.abort,
        dma_evt.crc_err,
        2'b00
    };

    wire [15:0] mst_set = {mst_evt.lbus_irq, mst_evt.lbus_timeout, 9'h000, mst_evt.parity_err, 4'h0};

    assign dma_status_d = ((dma_status_q & ~dma_rd_clr & ~dma_wr_clr) | dma_set) & DMA_IMPL;
    assign mst_status_d = ((mst_status_q & ~mst_rd_clr) | mst_set) & MST_IMPL;

    wire [15:0] dma_pend = dma_status_q & dma_mask_q;
    wire [15:0] mst_pend = mst_status_q & mst_mask_q;
    wire mst_local = mst_pend[MST_PAR_BIT] | mst_pend[MST_LBE_BIT];
    wire host_irq_d = (|dma_pend) | (|mst_pend);
    // Local pin only in configuration mode, local interrupt not looped back
    wire local_irq_d = cfg_sync_q & ((|dma_pend) | mst_local);

    assign prdata_d = !mapped ? 32'h0000_0000 :
                      sel_mst_st ? {16'h0000, mst_status_q} :
                      sel_mst_mk ? {16'h0000, mst_mask_q} :
                      sel_dma_st ? {16'h0000, dma_status_q} :
                      sel_dma_mk ? {16'h0000, dma_mask_q} :
                      sel_rxq ? {29'h0000_0000, rx_thr_q} :
                      sel_txq ? {29'h0000_0000, tx_thr_q} :
                      32'h0000_0000;
    assign pslverr_d = access & ~pready_q & ~mapped;

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= access & ~pready_q;
            pslverr_q <= pslverr_d;
            if (access & ~pready_q & ~pwrite) begin
                prdata_q <= prdata_d;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            dma_status_q <= REG_RESET;
            mst_status_q <= REG_RESET;
            rx_cnt_q <= 8'h00;
            tx_cnt_q <= 8'h00;
        end else begin
            dma_status_q <= dma_status_d;
            mst_status_q <= mst_status_d;
            rx_cnt_q <= rx_cnt_d;
            tx_cnt_q <= tx_cnt_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            dma_mask_q <= REG_RESET;
            mst_mask_q <= REG_RESET;
            rx_thr_q <= THR_RESET;
            tx_thr_q <= THR_RESET;
        end else if (wr_done) begin
            if (sel_dma_mk) begin
                dma_mask_q <= lane_merge(dma_mask_q, pwdata, pstrb) & DMA_IMPL;
            end
            if (sel_mst_mk) begin
                mst_mask_q <= lane_merge(mst_mask_q, pwdata, pstrb) & MST_IMPL;
            end
            if (sel_rxq & pstrb[0]) begin
                rx_thr_q <= pwdata[THR_LSB +: THR_W];
            end
            if (sel_txq & pstrb[0]) begin
                tx_thr_q <= pwdata[THR_LSB +: THR_W];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            cfg_meta_q <= 1'b0;
            cfg_sync_q <= 1'b0;
            host_irq_q <= 1'b0;
            local_irq_q <= 1'b0;
        end else begin
            cfg_meta_q <= local_cfg_mode;
            cfg_sync_q <= cfg_meta_q;
            host_irq_q <= host_irq_d;
            local_irq_q <= local_irq_d;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign host_irq_pin = host_irq_q;
    assign local_irq_pin = local_irq_q;
endmodule : dhsi_status_irq

// *** verif/dhsi_chk.sv ***
// Bus timing and interrupt pin checks for the status block
`timescale 1ns/1ps
module dhsi_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [dhsi_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire dhsi_pkg::dhsi_dma_evt_t dma_evt,
    input wire dhsi_pkg::dhsi_mst_evt_t mst_evt,
    input wire logic local_cfg_mode,
    input wire logic host_irq_pin,
    input wire logic local_irq_pin
);
    import dhsi_pkg::*;
    logic rd_done;
    assign rd_done = psel && !pwrite && pready;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    sequence s_setup;
        psel && !penable ##1 psel && penable;
    endsequence
    chk_one_wait: assert property (s_setup |-> !pready ##1 pready) else $error("bad wait");
    chk_ready_pulse: assert property (pready |=> !pready) else $error("ready long");
    chk_err_zero: assert property (rd_done && pslverr |-> prdata == 32'h0) else $error("err data");
    chk_upper_zero: assert property (rd_done |-> prdata[31:16] == 16'h0) else $error("upper set");
    chk_resv_zero: assert property (rd_done && paddr[7:3] == 5'h05 |-> prdata[1:0] == 2'h0) else $error("resv");
    chk_irq_cause: assert property ($rose(host_irq_pin) |-> $past(|dma_evt || |mst_evt || pready, 2)) else $error("rise");
    chk_irq_drop: assert property ($fell(host_irq_pin) |-> $past(pready, 2)) else $error("fall");
    chk_local_sub: assert property (local_irq_pin |-> host_irq_pin) else $error("local only");
    chk_local_cfg: assert property (!local_cfg_mode [*4] |-> !local_irq_pin) else $error("local mode");
endmodule : dhsi_chk
bind dhsi_status_irq dhsi_chk u_chk (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .dma_evt(dma_evt), .mst_evt(mst_evt),
    .local_cfg_mode(local_cfg_mode), .host_irq_pin(host_irq_pin), .local_irq_pin(local_irq_pin));

// *** verif/dhsi_host_model.sv ***
// Host side: counts interrupt requests seen on the pin
`timescale 1ns/1ps
module dhsi_host_model (
    input wire logic clk,
    input wire logic irq,
    output int irq_count
);
    logic seen_q = 1'b0;
    int count_q = 0;
    assign irq_count = count_q;
    always @(posedge clk) begin
        seen_q <= irq;
        if (irq && !seen_q) begin
            count_q <= count_q + 1;
        end
    end
endmodule : dhsi_host_model

// *** verif/tb.sv ***
// Directed bench for event latching, masks and interrupt pins
`timescale 1ns/1ps
module tb;
    import dhsi_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    dhsi_dma_evt_t dma_evt = '0;
    dhsi_mst_evt_t mst_evt = '0;
    logic cfg = 1'b0;
    logic hirq;
    logic lirq;
    logic [31:0] rd;
    logic perr;
    int irqs;
    int fails = 0;
    int comparisons = 0;
    always #2 clk = ~clk;
    dhsi_status_irq u_dut (.clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .dma_evt(dma_evt), .mst_evt(mst_evt), .local_cfg_mode(cfg), .host_irq_pin(hirq), .local_irq_pin(lirq));
    dhsi_host_model u_host (.clk(clk), .irq(hirq), .irq_count(irqs));
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            fails++;
            $display("wrong value t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n == 50) fails++;
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : acc
    task automatic pulse(input int b);
        dma_evt[15-b] <= 1'b1;
        @(posedge clk);
        dma_evt <= '0;
        @(posedge clk);
    endtask : pulse
    task automatic t_reset;
        acc(1'b0, DMA_STATUS_OFS, 32'h0);
        chk(rd, 32'h0);
        acc(1'b0, DMA_MASK_OFS, 32'h0);
        chk(rd, 32'h0);
        acc(1'b1, DMA_MASK_OFS, 32'hFFFFFFFF);
        acc(1'b0, DMA_MASK_OFS, 32'h0);
        chk(rd, 32'h0000FFFC);
        pstrb <= 4'h2;
        acc(1'b1, DMA_MASK_OFS, 32'h0);
        pstrb <= 4'hF;
        acc(1'b0, DMA_MASK_OFS, 32'h0);
        chk(rd, 32'h000000FC);
        acc(1'b1, DMA_MASK_OFS, 32'hFFFFFFFF);
        acc(1'b0, 8'h40, 32'h0);
        chk({rd[31:1], perr}, 32'h1);
    endtask : t_reset
    task automatic t_events;
        for (int b = 2; b < 16; b++) begin
            pulse(b);
            @(posedge clk);
            chk({30'h0, hirq, lirq}, 32'h2);
            acc(1'b0, DMA_STATUS_OFS, 32'h0);
            chk(rd, 32'h1 << b);
            acc(1'b0, DMA_STATUS_OFS, 32'h0);
            chk(rd, 32'h0);
        end
    endtask : t_events
    task automatic t_thresh(input logic [7:0] a, input int b, input int t);
        acc(1'b1, a, 32'(t));
        dma_evt[15-b] <= 1'b1;
        repeat ((1 << t) - 1) @(posedge clk);
        dma_evt <= '0;
        @(posedge clk);
        acc(1'b0, DMA_STATUS_OFS, 32'h0);
        chk(rd, 32'h0);
        pulse(b);
        acc(1'b0, DMA_STATUS_OFS, 32'h0);
        chk(rd, 32'h1 << b);
        acc(1'b1, a, 32'h0);
    endtask : t_thresh
    task automatic t_irq;
        cfg <= 1'b1;
        fork
            acc(1'b0, DMA_STATUS_OFS, 32'h0);
            begin
                repeat (2) @(posedge clk);
                dma_evt.crc_err <= 1'b1;
                @(posedge clk);
                dma_evt.crc_err <= 1'b0;
            end
        join
        repeat (2) @(posedge clk);
        chk({30'h0, hirq, lirq}, 32'h3);
        acc(1'b0, DMA_STATUS_OFS, 32'h0);
        chk(rd, 32'h4);
    endtask : t_irq
    task automatic t_clear;
        pulse(5);
        pulse(9);
        acc(1'b1, DMA_CLEAR_OFS, 32'h0000_0020);
        acc(1'b0, DMA_STATUS_OFS, 32'h0);
        chk(rd, 32'h0000_0200);
        acc(1'b1, DMA_MASK_OFS, 32'h0);
        pulse(12);
        @(posedge clk);
        chk({30'h0, hirq, lirq}, 32'h0);
        acc(1'b0, DMA_STATUS_OFS, 32'h0);
        chk(rd, 32'h0000_1000);
    endtask : t_clear
    task automatic t_master;
        acc(1'b1, MST_MASK_OFS, 32'h8000);
        mst_evt <= 3'b100;
        @(posedge clk);
        mst_evt <= '0;
        repeat (3) @(posedge clk);
        chk({30'h0, hirq, lirq}, 32'h0);
        mst_evt <= 3'b001;
        @(posedge clk);
        mst_evt <= '0;
        repeat (3) @(posedge clk);
        chk({30'h0, hirq, lirq}, 32'h2);
        acc(1'b0, MST_STATUS_OFS, 32'h0);
        chk(rd, 32'h8010);
    endtask : t_master
    task automatic conclude;
        if (fails == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        t_reset();
        t_events();
        t_thresh(RX_QCTL_OFS, 10, 7);
        t_thresh(TX_QCTL_OFS, 14, 1);
        t_irq();
        t_clear();
        t_master();
        chk({31'h0, irqs > 0}, 32'h1);
        conclude();
    end
    initial begin
        #40000;
        fails++;
        conclude();
    end
endmodule : tb
